// ===== logic/tcpu_core.sv
// Timer/counter/pulse unit: counter, prescaler, compare/capture, PWM variants.
// Assumes event sources and kill come from outside the clock domain.
// Functional notes
// - Compare, capture, quadrature, PWM, random PWM, dead-time functions.
// - Count up, down, or up then down.
// - Prescaler divides by powers of two, 1..128.
// - Compare and period have software-written buffered copies.
// - Underflow, overflow, capture/compare pulse outputs.
// - Terminal count interrupt on overflow or underflow.
// - Capture/compare interrupt on capture or match.
// - PWM functions give a complementary output.
// - Five selectable event inputs: start, reload, stop, count, capture.
// - Each event: rising, falling, both edges, or level.
// - Kill forces outputs to configured safe state.
`timescale 1ns/1ps
module tcpu_core
#(
  parameter int WIDTH = tcpu_pkg::TCPU_WIDTH_DEF
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire tcpu_pkg::tcpu_func_t func_in,
  input wire tcpu_pkg::tcpu_dir_t dir_in,
  input wire logic [2:0] presc_log_in,
  input wire logic [WIDTH-1:0] period_buf_in,
  input wire logic [WIDTH-1:0] cc_buf_in,
  input wire logic swap_in,
  input wire logic [7:0] dead_time_in,
  input wire logic [4:0] evt_src_in [5],
  input wire logic [1:0] evt_mode_in [5],
  input wire logic [31:0] trig_in,
  input wire logic kill_in,
  input wire logic kill_level_in,
  input wire logic kill_level_cmp_in,
  output logic [WIDTH-1:0] count_out,
  output logic [WIDTH-1:0] capture_out,
  output logic [WIDTH-1:0] period_out,
  output logic [WIDTH-1:0] compare_out,
  output logic running_out,
  output logic underflow_out,
  output logic overflow_out,
  output logic cc_out,
  output logic irq_tc_out,
  output logic irq_cc_out,
  output logic pwm_out,
  output logic pwm_n_out
);
  // Event order: 0 start, 1 reload, 2 stop, 3 count, 4 capture.
  logic [4:0] evt;
  logic kill_s1_ff;
  logic kill_s2_ff;

  // Per-event source selection and detection.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_evt
      tcpu_event_det u_det
      (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sig_in(trig_in[evt_src_in[gi]]),
        .mode_in(evt_mode_in[gi]),
        .evt_out(evt[gi])
      );
    end
  endgenerate

  // Kill is synchronised before any logic reads it.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      kill_s1_ff <= 1'b0;
      kill_s2_ff <= 1'b0;
    end
    else
    begin
      kill_s1_ff <= kill_in;
      kill_s2_ff <= kill_s1_ff;
    end
  end

  // Core state.
  logic [WIDTH-1:0] cnt_ff, nxt_cnt;
  logic [WIDTH-1:0] per_ff, nxt_per;
  logic [WIDTH-1:0] cmp_ff, nxt_cmp;
  logic [WIDTH-1:0] cap_ff, nxt_cap;
  logic [6:0] pre_ff, nxt_pre;
  logic run_ff, nxt_run;
  logic down_ff, nxt_down;
  logic uf_ff, nxt_uf;
  logic of_ff, nxt_of;
  logic cc_ff, nxt_cc;
  logic swap_pend_ff, nxt_swap_pend;
  logic pwm_raw_ff, nxt_pwm_raw;
  logic [31:0] lfsr_ff, nxt_lfsr;
  logic [1:0] qab_ff, nxt_qab;
  logic tick;
  logic [6:0] pre_mask;

  // Terminal value of the prescaler: all ones in the low presc_log bits.
  always_comb
  begin
    pre_mask = 7'(({7'h00, 1'b1} << presc_log_in) - 8'h01);
    tick = (pre_ff & pre_mask) == pre_mask;
  end

  // Next-state logic for counter, buffers, events and PWM level.
  always_comb
  begin
    logic step;
    logic go_down;
    logic at_end;
    logic ovf;
    logic unf;
    logic [1:0] qd;
    step = 1'b0;
    go_down = down_ff;
    at_end = 1'b0;
    ovf = 1'b0;
    unf = 1'b0;
    qd = 2'h0;
    nxt_cnt = cnt_ff;
    nxt_per = per_ff;
    nxt_cmp = cmp_ff;
    nxt_cap = cap_ff;
    nxt_pre = pre_ff;
    nxt_run = run_ff;
    nxt_down = down_ff;
    nxt_uf = 1'b0;
    nxt_of = 1'b0;
    nxt_cc = 1'b0;
    nxt_swap_pend = swap_pend_ff | swap_in;
    nxt_pwm_raw = pwm_raw_ff;
    nxt_lfsr = lfsr_ff;
    nxt_qab = {evt[3], evt[4]};
    // Start and stop; stop wins when both arrive.
    if (evt[0] && enable_in)
    begin
      nxt_run = 1'b1;
    end
    if (evt[2] || !enable_in)
    begin
      nxt_run = 1'b0;
    end
    // Reload restarts the count from the direction's origin.
    if (evt[1] && enable_in)
    begin
      nxt_run = 1'b1;
      nxt_cnt = (dir_in == tcpu_pkg::TCPU_DIR_DOWN) ? per_ff : '0;
      nxt_down = (dir_in == tcpu_pkg::TCPU_DIR_DOWN);
    end
    else if (run_ff)
    begin
      nxt_pre = (tick) ? 7'h00 : 7'(pre_ff + 7'h01);
      if (func_in == tcpu_pkg::TCPU_FN_QUAD)
      begin
        // Quadrature: count and capture inputs carry phases A and B.
        qd = qab_ff ^ {evt[3], evt[4]};
        if (qd != 2'h0)
        begin
          step = 1'b1;
          go_down = (qab_ff[1] ^ evt[4]) ? 1'b0 : 1'b1;
          if (qd == 2'h3)
          begin
            step = 1'b0;
          end
        end
      end
      else
      begin
        // A level-mode count input counts on every tick only while it is active.
        step = tick && evt[3];
      end
      if (step)
      begin
        // Terminal points at period or at the width limit counting up, at zero counting down.
        if (!go_down)
        begin
          at_end = (cnt_ff == per_ff) || (cnt_ff == '1);
          if (at_end && dir_in == tcpu_pkg::TCPU_DIR_UPDN)
          begin
            nxt_down = 1'b1;
            nxt_cnt = WIDTH'(cnt_ff - 1'b1);
            ovf = 1'b1;
          end
          else if (at_end)
          begin
            nxt_cnt = '0;
            ovf = 1'b1;
          end
          else
          begin
            nxt_cnt = WIDTH'(cnt_ff + 1'b1);
          end
        end
        else
        begin
          at_end = (cnt_ff == '0);
          if (at_end && dir_in == tcpu_pkg::TCPU_DIR_UPDN)
          begin
            nxt_down = 1'b0;
            nxt_cnt = WIDTH'(cnt_ff + 1'b1);
            unf = 1'b1;
          end
          else if (at_end)
          begin
            nxt_cnt = per_ff;
            unf = 1'b1;
          end
          else
          begin
            nxt_cnt = WIDTH'(cnt_ff - 1'b1);
          end
        end
        if (func_in != tcpu_pkg::TCPU_FN_QUAD && dir_in != tcpu_pkg::TCPU_DIR_UPDN)
        begin
          nxt_down = (dir_in == tcpu_pkg::TCPU_DIR_DOWN);
        end
        nxt_lfsr = {lfsr_ff[30:0], ^(lfsr_ff & tcpu_pkg::TCPU_LFSR_TAPS)};
      end
    end
    nxt_of = ovf;
    nxt_uf = unf;
    // Swap buffered values only at a terminal point, never mid-period.
    if ((ovf || unf) && swap_pend_ff)
    begin
      nxt_per = period_buf_in;
      nxt_cmp = cc_buf_in;
      nxt_swap_pend = swap_in;
    end
    // Capture or compare event.
    if (func_in == tcpu_pkg::TCPU_FN_CAPTURE)
    begin
      if (evt[4] && run_ff)
      begin
        nxt_cap = cnt_ff;
        nxt_cc = 1'b1;
      end
    end
    else if (func_in != tcpu_pkg::TCPU_FN_QUAD)
    begin
      nxt_cc = step && (nxt_cnt == cmp_ff);
    end
    // PWM level: below compare is active, random variant compares LFSR.
    if (func_in == tcpu_pkg::TCPU_FN_PRPWM)
    begin
      nxt_pwm_raw = WIDTH'(lfsr_ff[WIDTH-1:0]) < cmp_ff;
    end
    else
    begin
      nxt_pwm_raw = nxt_cnt < cmp_ff;
    end
  end

  // Registers only.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_ff <= '0;
      per_ff <= '1;
      cmp_ff <= '0;
      cap_ff <= '0;
      pre_ff <= tcpu_pkg::TCPU_PRESC_RESET;
      run_ff <= 1'b0;
      down_ff <= 1'b0;
      uf_ff <= 1'b0;
      of_ff <= 1'b0;
      cc_ff <= 1'b0;
      swap_pend_ff <= 1'b0;
      pwm_raw_ff <= 1'b0;
      lfsr_ff <= tcpu_pkg::TCPU_LFSR_SEED;
      qab_ff <= 2'h0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      per_ff <= nxt_per;
      cmp_ff <= nxt_cmp;
      cap_ff <= nxt_cap;
      pre_ff <= nxt_pre;
      run_ff <= nxt_run;
      down_ff <= nxt_down;
      uf_ff <= nxt_uf;
      of_ff <= nxt_of;
      cc_ff <= nxt_cc;
      swap_pend_ff <= nxt_swap_pend;
      pwm_raw_ff <= nxt_pwm_raw;
      lfsr_ff <= nxt_lfsr;
      qab_ff <= nxt_qab;
    end
  end

  // Dead-time insertion: each rising edge waits dead_time prescaled ticks.
  logic [tcpu_pkg::TCPU_DT_WIDTH-1:0] dt_ff, nxt_dt;
  logic pwm_ff, nxt_pwm;
  logic pwmn_ff, nxt_pwmn;
  logic pwm_fn;

  // Outputs follow the raw level; dead time only holds back the rise.
  always_comb
  begin
    pwm_fn = (func_in == tcpu_pkg::TCPU_FN_PWM) || (func_in == tcpu_pkg::TCPU_FN_PRPWM)
             || (func_in == tcpu_pkg::TCPU_FN_PWM_DT);
    nxt_dt = dt_ff;
    nxt_pwm = pwm_raw_ff;
    nxt_pwmn = ~pwm_raw_ff;
    if (func_in == tcpu_pkg::TCPU_FN_PWM_DT)
    begin
      // Both low while the dead counter runs, so they never overlap.
      if (pwm_raw_ff != pwm_ff || pwm_raw_ff == pwmn_ff)
      begin
        nxt_pwm = 1'b0;
        nxt_pwmn = 1'b0;
        if (dt_ff == dead_time_in)
        begin
          nxt_pwm = pwm_raw_ff;
          nxt_pwmn = ~pwm_raw_ff;
          nxt_dt = '0;
        end
        else if (tick)
        begin
          nxt_dt = tcpu_pkg::TCPU_DT_WIDTH'(dt_ff + 1'b1);
        end
      end
      else
      begin
        nxt_dt = '0;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dt_ff <= '0;
      pwm_ff <= 1'b0;
      pwmn_ff <= 1'b0;
    end
    else
    begin
      dt_ff <= nxt_dt;
      pwm_ff <= nxt_pwm;
      pwmn_ff <= nxt_pwmn;
    end
  end

  // Kill overrides the drive with configured safe levels.
  assign pwm_out = kill_s2_ff ? kill_level_in : (pwm_fn & pwm_ff);
  assign pwm_n_out = kill_s2_ff ? kill_level_cmp_in : (pwm_fn & pwmn_ff);
  assign count_out = cnt_ff;
  assign capture_out = cap_ff;
  assign period_out = per_ff;
  assign compare_out = cmp_ff;
  assign running_out = run_ff;
  assign underflow_out = uf_ff;
  assign overflow_out = of_ff;
  assign cc_out = cc_ff;
  assign irq_tc_out = uf_ff | of_ff;
  assign irq_cc_out = cc_ff;
endmodule

// ===== logic/tcpu_pkg.sv
// Constants and types shared by the timer/counter/pulse unit.
// Assumes one clock domain; no register bus, configuration arrives on plain ports.
package tcpu_pkg;
  // Operating functions.
  typedef enum logic [2:0] {
    TCPU_FN_COMPARE = 3'h0,
    TCPU_FN_CAPTURE = 3'h1,
    TCPU_FN_QUAD = 3'h2,
    TCPU_FN_PWM = 3'h3,
    TCPU_FN_PRPWM = 3'h4,
    TCPU_FN_PWM_DT = 3'h5
  } tcpu_func_t;
  // Count directions.
  typedef enum logic [1:0] {
    TCPU_DIR_UP = 2'h0,
    TCPU_DIR_DOWN = 2'h1,
    TCPU_DIR_UPDN = 2'h2
  } tcpu_dir_t;
  // Event detection kinds.
  localparam logic [1:0] TCPU_EDGE_RISE = 2'h0;
  localparam logic [1:0] TCPU_EDGE_FALL = 2'h1;
  localparam logic [1:0] TCPU_EDGE_BOTH = 2'h2;
  localparam logic [1:0] TCPU_EDGE_LEVEL = 2'h3;
  // Largest prescaler exponent: divide by 2**7 = 128.
  localparam int TCPU_PRESC_MAX_LOG = 7;
  localparam logic [6:0] TCPU_PRESC_RESET = 7'h00;
  // Default counter width.
  localparam int TCPU_WIDTH_DEF = 32;
  // Pseudo-random generator seed and tap mask.
  localparam logic [31:0] TCPU_LFSR_SEED = 32'h0000_0001;
  localparam logic [31:0] TCPU_LFSR_TAPS = 32'h8020_0003;
  // Dead time counter width.
  localparam int TCPU_DT_WIDTH = 8;
endpackage

// ===== logic/tcpu_event_det.sv
// Event input detector for the timer/counter/pulse unit.
// Assumes the input comes from outside the clock domain; it is synchronised here.
`timescale 1ns/1ps
module tcpu_event_det
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sig_in,
  input wire logic [1:0] mode_in,
  output logic evt_out
);
  // Two-stage synchroniser, then one history stage for edge detection.
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic nxt_sync1;
  logic nxt_sync2;
  logic nxt_prev;
  // Counts the clock cycles since reset; edges stay masked until the history holds a real pin value.
  logic [1:0] age_ff;
  logic [1:0] nxt_age;
  logic armed;

  // Next values: the first stage feeds only the second stage.
  always_comb
  begin
    nxt_sync1 = sig_in;
    nxt_sync2 = sync1_ff;
    nxt_prev = sync2_ff;
    nxt_age = (age_ff == 2'h3) ? age_ff : 2'(age_ff + 2'h1);
  end

  // Registers only.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
      age_ff <= 2'h0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff <= nxt_prev;
      age_ff <= nxt_age;
    end
  end

  // Detection kind selects the pulse shape.
  // A pin that idles high would otherwise look like a rising edge right after reset.
  always_comb
  begin
    armed = (age_ff == 2'h3);
    unique case (mode_in)
      tcpu_pkg::TCPU_EDGE_RISE: evt_out = armed & sync2_ff & ~prev_ff;
      tcpu_pkg::TCPU_EDGE_FALL: evt_out = armed & ~sync2_ff & prev_ff;
      tcpu_pkg::TCPU_EDGE_BOTH: evt_out = armed & (sync2_ff ^ prev_ff);
      tcpu_pkg::TCPU_EDGE_LEVEL: evt_out = sync2_ff;
    endcase
  end
endmodule

// ===== test/tcpu_core_asserts.sv
// Port checker for the timer/counter/pulse unit.
// Assumes one clock, asynchronous active-high reset, bound into tcpu_core.
`timescale 1ns/1ps
module tcpu_core_asserts
#(
  parameter int WIDTH = 32
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire tcpu_pkg::tcpu_func_t func_in,
  input wire tcpu_pkg::tcpu_dir_t dir_in,
  input wire logic kill_in,
  input wire logic kill_level_in,
  input wire logic kill_level_cmp_in,
  input wire logic [WIDTH-1:0] count_out,
  input wire logic underflow_out,
  input wire logic overflow_out,
  input wire logic cc_out,
  input wire logic irq_tc_out,
  input wire logic irq_cc_out,
  input wire logic pwm_out,
  input wire logic pwm_n_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Kill must outlast the two-stage synchroniser before outputs obey it.
  sequence kill_held;
    kill_in[*4];
  endsequence
  sequence kill_quiet;
    (!kill_in)[*4];
  endsequence
  a_tc_irq_src: assert property (irq_tc_out == (underflow_out | overflow_out))
    else $error("terminal irq differs from wrap pulses");
  a_cc_irq_src: assert property (irq_cc_out == cc_out)
    else $error("match irq differs from match pulse");
  a_pwm_inverse: assert property (kill_quiet ##0 ((func_in == tcpu_pkg::TCPU_FN_PWM
    || func_in == tcpu_pkg::TCPU_FN_PRPWM) && $past(func_in, 2) == func_in)
    |-> pwm_n_out == !pwm_out)
    else $error("second output is not the inverse");
  a_kill_safe: assert property (kill_held ##0 func_in == tcpu_pkg::TCPU_FN_PWM_DT
    |-> pwm_out == kill_level_in && pwm_n_out == kill_level_cmp_in)
    else $error("outputs not at safe levels");
  a_dt_no_overlap: assert property (func_in == tcpu_pkg::TCPU_FN_PWM_DT
    && $past(func_in) == func_in && kill_level_in != kill_level_cmp_in
    |-> !(pwm_out && pwm_n_out))
    else $error("both outputs active together");
  a_hold_off: assert property ((!enable_in)[*4] |-> $stable(count_out))
    else $error("count moved while disabled");
  a_wrap_zero: assert property (overflow_out && dir_in == tcpu_pkg::TCPU_DIR_UP
    && $past(dir_in, 3) == dir_in |-> count_out == 0 || $past(count_out) == 0)
    else $error("overflow without return to zero");
  a_wrap_apart: assert property (!(overflow_out && underflow_out))
    else $error("overflow and underflow together");
endmodule
bind tcpu_core tcpu_core_asserts #(.WIDTH(WIDTH)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .enable_in(enable_in), .func_in(func_in), .dir_in(dir_in), .kill_in(kill_in),
  .kill_level_in(kill_level_in), .kill_level_cmp_in(kill_level_cmp_in),
  .count_out(count_out), .underflow_out(underflow_out), .overflow_out(overflow_out),
  .cc_out(cc_out), .irq_tc_out(irq_tc_out), .irq_cc_out(irq_cc_out),
  .pwm_out(pwm_out), .pwm_n_out(pwm_n_out));

// ===== test/tcpu_trig_model.sv
// Model of the on-chip trigger sources and the kill source.
// Assumes the caller runs its tasks from one process, on clk_in.
`timescale 1ns/1ps
module tcpu_trig_model
(
  input wire logic clk_in,
  output logic [31:0] trig_out,
  output logic kill_out
);
  // Line 0 idles high so a level-mode count event ticks every cycle.
  initial
  begin
    trig_out = 32'h0000_0001;
    kill_out = 1'b0;
  end
  // Sources change just after an edge and hold at least two cycles.
  task automatic set_src(input int idx, input logic val);
    @(posedge clk_in);
    trig_out[idx] <= val;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic pulse_src(input int idx);
    set_src(idx, 1'b1);
    trig_out[idx] <= 1'b0;
  endtask
  task automatic set_kill(input logic val);
    @(posedge clk_in);
    kill_out <= val;
  endtask
endmodule

// ===== test/tb_timer_counter_pwm.sv
// Self-checking bench for the timer/counter/pulse unit at 16 bits.
// Assumes tcpu_core, its checker bind and the trigger model are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module tb_timer_counter_pwm;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic enable = 1'b0;
  tcpu_pkg::tcpu_func_t func = tcpu_pkg::TCPU_FN_COMPARE;
  tcpu_pkg::tcpu_dir_t dir = tcpu_pkg::TCPU_DIR_UP;
  logic [2:0] presc = 3'h0;
  logic [15:0] per_buf = 16'h0005;
  logic [15:0] cc_buf = 16'h0002;
  logic swap = 1'b1;
  logic [7:0] dtime = 8'h02;
  // Safe levels are driven so that both polarities of the kill state are exercised.
  logic kill_lvl = 1'b1;
  logic kill_lvl_cmp = 1'b0;
  logic [4:0] src [5] = '{5'h01, 5'h02, 5'h03, 5'h00, 5'h04};
  logic [1:0] mode [5] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h0};
  logic [31:0] trig;
  logic kill;
  logic [15:0] count, capture, period, compare, c0;
  logic running, unf, ovf, cc, itc, icc, pwm, pwm_n;
  int err_total = 0;
  int num_checks = 0;
  int n;
  always #4 clk_in = ~clk_in;
  tcpu_trig_model trig_src (.clk_in(clk_in), .trig_out(trig), .kill_out(kill));
  tcpu_core #(.WIDTH(16)) dut (.clk_in(clk_in), .rst_in(rst_in), .enable_in(enable),
    .func_in(func), .dir_in(dir), .presc_log_in(presc), .period_buf_in(per_buf),
    .cc_buf_in(cc_buf), .swap_in(swap), .dead_time_in(dtime), .evt_src_in(src),
    .evt_mode_in(mode), .trig_in(trig), .kill_in(kill), .kill_level_in(kill_lvl),
    .kill_level_cmp_in(kill_lvl_cmp), .count_out(count), .capture_out(capture),
    .period_out(period), .compare_out(compare), .running_out(running),
    .underflow_out(unf), .overflow_out(ovf), .cc_out(cc), .irq_tc_out(itc),
    .irq_cc_out(icc), .pwm_out(pwm), .pwm_n_out(pwm_n));
  // Waits for a chosen output under a bound; a miss counts as a mismatch.
  task automatic wait_for(input int sel, input int lim, output int k);
    logic hit;
    k = 0;
    hit = 1'b0;
    while (!hit && k < lim)
    begin
      @(posedge clk_in);
      #1;
      k++;
      case (sel)
        0: hit = (running === 1'b1);
        1: hit = (ovf === 1'b1);
        2: hit = (unf === 1'b1);
        3: hit = (cc === 1'b1);
        default: hit = (count !== c0);
      endcase
    end
    `CHK(hit, 1'b1)
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run is just over 66000 cycles; the first wrap of the reset period dominates.
  initial
  begin
    #(90000 * 8);
    err_total++;
    close_out();
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    `CHK(count, 16'h0000)
    `CHK(period, 16'hffff)
    @(posedge clk_in);
    enable <= 1'b1;
    trig_src.pulse_src(1);
    wait_for(0, 20, n);
    wait_for(1, 70000, n);
    wait_for(1, 300, n);
    wait_for(1, 20, n);
    `CHK(n, 6)
    `CHK(itc, 1'b1)
    `CHK(period, 16'h0005)
    wait_for(3, 20, n);
    wait_for(3, 20, n);
    `CHK(n, 6)
    `CHK(icc, 1'b1)
    `CHK(compare, 16'h0002)
    // The request already latched is still honoured at the next terminal point.
    swap <= 1'b0;
    per_buf <= 16'h0007;
    cc_buf <= 16'h0003;
    wait_for(1, 20, n);
    `CHK(period, 16'h0007)
    `CHK(compare, 16'h0003)
    // Without a new request a changed buffer must not reach the active period.
    per_buf <= 16'h0005;
    wait_for(1, 20, n);
    wait_for(1, 20, n);
    `CHK(n, 8)
    `CHK(period, 16'h0007)
    dir <= tcpu_pkg::TCPU_DIR_DOWN;
    wait_for(2, 40, n);
    wait_for(2, 20, n);
    `CHK(n, 8)
    `CHK(itc, 1'b1)
    dir <= tcpu_pkg::TCPU_DIR_UPDN;
    wait_for(1, 40, n);
    wait_for(2, 20, n);
    `CHK(n, 7)
    dir <= tcpu_pkg::TCPU_DIR_UP;
    for (int p = 0; p < 8; p++)
    begin
      presc <= p[2:0];
      c0 = count;
      wait_for(4, 300, n);
      c0 = count;
      wait_for(4, 300, n);
      `CHK(n, 1 << p)
    end
    // Stop is rerouted to line 5 so that the source selection is exercised.
    src[2] <= 5'h05;
    trig_src.pulse_src(5);
    repeat (4) @(posedge clk_in);
    #1;
    `CHK(running, 1'b0)
    presc <= 3'h0;
    // Start under each edge kind; the level kind is already on the count input.
    for (int m = 0; m < 3; m++)
    begin
      trig_src.pulse_src(5);
      repeat (6) @(posedge clk_in);
      #1;
      `CHK(running, 1'b0)
      mode[0] <= m[1:0];
      trig_src.set_src(1, m != 1);
      wait_for(0, 20, n);
    end
    func <= tcpu_pkg::TCPU_FN_CAPTURE;
    trig_src.pulse_src(4);
    wait_for(3, 10, n);
    `CHK(capture <= 16'h0007, 1'b1)
    // Phases are read as levels; the tail of the capture pulse settles before the reference.
    func <= tcpu_pkg::TCPU_FN_QUAD;
    mode[3] <= 2'h3;
    mode[4] <= 2'h3;
    repeat (3) @(posedge clk_in);
    #1;
    c0 = count;
    // One full gray cycle of the two phases moves the count by four, modulo a period of 8.
    for (int q = 0; q < 4; q++)
      trig_src.set_src(q[0] ? 0 : 4, (q[1] ^ q[0]) ? 1'b0 : 1'b1);
    repeat (4) @(posedge clk_in);
    #1;
    `CHK(count, 16'((c0 + 16'h0004) & 16'h0007))
    trig_src.set_src(0, 1'b1);
    mode[3] <= 2'h3;
    dtime <= 8'h03;
    for (int f = 3; f < 6; f++)
    begin
      func <= tcpu_pkg::tcpu_func_t'(f);
      repeat (20) @(posedge clk_in);
      #1;
      if (f != 5)
        `CHK(pwm_n, ~pwm)
      else
        `CHK(pwm & pwm_n, 1'b0)
    end
    trig_src.set_kill(1'b1);
    repeat (6) @(posedge clk_in);
    #1;
    `CHK({pwm, pwm_n}, 2'h2)
    // Swapped safe levels must show at once while kill stays active.
    kill_lvl <= 1'b0;
    kill_lvl_cmp <= 1'b1;
    @(posedge clk_in);
    #1;
    `CHK({pwm, pwm_n}, 2'h1)
    trig_src.set_kill(1'b0);
    enable <= 1'b0;
    repeat (4) @(posedge clk_in);
    c0 = count;
    repeat (8) @(posedge clk_in);
    `CHK(count, c0)
    close_out();
  end
endmodule
